// [core/ld_cfg_pkg.sv]
// constants, types and register layout of the logical device bank
// assumes one clock domain and byte-wide index/data host ports
package ld_cfg_pkg;
  localparam logic [7:0] KEY_ENTER      = 8'h55;
  localparam logic [7:0] KEY_EXIT       = 8'hAA;
  localparam logic [7:0] IDX_CFG_CTRL   = 8'h02;
  localparam logic [7:0] IDX_DEV_SELECT = 8'h07;
  localparam logic [7:0] IDX_LD_FIRST   = 8'h30;
  localparam int         SOFT_BIT       = 0;
  localparam logic [7:0] LD_FLOPPY   = 8'h00;
  localparam logic [7:0] LD_PRINTER  = 8'h03;
  localparam logic [7:0] LD_SERIAL_A = 8'h04;
  localparam logic [7:0] LD_SERIAL_B = 8'h05;
  localparam logic [7:0] LD_KEYBOARD = 8'h07;
  localparam logic [7:0] LD_AUX      = 8'h08;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_SPARE_HI = 8'h62;
  localparam logic [7:0] IDX_SPARE_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ      = 8'h70;
  localparam logic [7:0] IDX_IRQ_2ND  = 8'h72;
  localparam logic [7:0] IDX_DMA      = 8'h74;
  localparam logic [7:0] IDX_F0       = 8'hF0;
  localparam logic [7:0] IDX_F1       = 8'hF1;
  localparam logic [7:0] IDX_F2       = 8'hF2;
  localparam logic [7:0] IDX_F3       = 8'hF3;
  localparam logic [7:0] IDX_F4       = 8'hF4;
  localparam logic [7:0] IDX_F5       = 8'hF5;
  localparam logic [7:0] IDX_EVT_EN_A = 8'hB4;
  localparam logic [7:0] IDX_EVT_EN_B = 8'hB5;
  localparam logic [7:0] IDX_EVT_ST_A = 8'hB6;
  localparam logic [7:0] IDX_EVT_ST_B = 8'hB7;
  localparam logic [7:0] IDX_PIN_MUX  = 8'hC0;
  localparam logic [7:0] IDX_MEDIA    = 8'hC1;
  localparam logic [7:0] IDX_RATE_MIR = 8'hC2;
  localparam logic [7:0] IDX_FIFO_A   = 8'hC3;
  localparam logic [7:0] IDX_FIFO_B   = 8'hC4;
  localparam logic [7:0] IDX_PWR_CTL  = 8'hC5;
  localparam logic [7:0] IDX_PWR_ST   = 8'hC6;
  localparam logic [7:0] IDX_WAKE_ST  = 8'hC7;
  localparam logic [7:0] IDX_WAKE_EN  = 8'hC8;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [15:0] RST_BASE       = 16'h0000;
  localparam logic [7:0] RST_FLOPPY_MODE = 8'h0E;
  localparam logic [7:0] RST_FLOPPY_TYPE = 8'hFF;
  localparam logic [7:0] RST_PRINTER_DMA = 8'h04;
  localparam logic [7:0] RST_PRINTER_MODE = 8'h3C;
  localparam logic [7:0] RST_IR_OPTIONS  = 8'h02;
  localparam logic [7:0] RST_IR_TIMEOUT  = 8'h03;
  localparam logic [7:0] RST_PIN_MUX     = 8'h02;
  localparam logic [7:0] RST_MEDIA       = 8'h01;
  localparam logic [7:0] WDT_WRITE_MASK  = 8'h0F;
  localparam logic [7:0] WDT_READ_MASK   = 8'hF0;

  typedef enum logic {run_mode = 1'b0, cfg_mode = 1'b1} mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_port;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [7:0]  floppy_mode_cfg;
    logic [7:0]  floppy_option_cfg;
    logic [7:0]  floppy_type_cfg;
    logic [7:0]  floppy_drive_a_cfg;
    logic [7:0]  floppy_drive_b_cfg;
    logic [7:0]  printer_activate;
    logic [15:0] printer_base_address;
    logic [7:0]  printer_irq_select;
    logic [7:0]  printer_dma_select;
    logic [7:0]  printer_mode_cfg;
    logic [7:0]  printer_mode_cfg_second;
    logic [7:0]  serial_a_activate;
    logic [15:0] serial_a_base_address;
    logic [7:0]  serial_a_irq_select;
    logic [7:0]  serial_a_mode_cfg;
    logic [7:0]  serial_b_activate;
    logic [15:0] serial_b_base_address;
    logic [15:0] serial_b_spare_pair;
    logic [7:0]  serial_b_irq_select;
    logic [7:0]  serial_b_mode_cfg;
    logic [7:0]  infrared_options;
    logic [7:0]  infrared_turnaround_timeout;
    logic [7:0]  keyboard_activate;
    logic [7:0]  keyboard_irq_select;
    logic [7:0]  mouse_irq_select;
    logic [7:0]  keyboard_reset_gate_select;
    logic [7:0]  aux_activate;
    logic [7:0]  mgmt_event_enable_a;
    logic [7:0]  mgmt_event_enable_b;
    logic [7:0]  mgmt_event_status_a;
    logic [7:0]  mgmt_event_status_b;
    logic [7:0]  pin_sharing_controls;
    logic [7:0]  media_change_force;
    logic [7:0]  power_event_control;
    logic [7:0]  power_event_status;
    logic [7:0]  wake_event_status;
    logic [7:0]  wake_event_enable;
    logic [7:0]  watchdog_timeout_cfg;
    logic [7:0]  watchdog_count;
    logic [7:0]  watchdog_setup;
    logic [7:0]  watchdog_command;
  } bank_t;
endpackage

// [core/logical_device_config_bank.sv]
// logical device configuration bank behind the index and data ports
// assumes host strobes are one-cycle pulses synchronous to sys_clk;
// sys_rst stands for the standby-supply power-on
`timescale 1ns/10ps
module logical_device_config_bank
  import ld_cfg_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  hard_reset,
  input  wire logic                  main_por,
  input  wire ld_cfg_pkg::host_req_t host_req,
  input  wire logic [7:0]            floppy_rate_src,
  input  wire logic [7:0]            serial_a_fifo_src,
  input  wire logic [7:0]            serial_b_fifo_src,
  input  wire logic [7:0]            power_event_set,
  input  wire logic [7:0]            wake_event_set,
  input  wire logic [7:0]            watchdog_state,
  output logic [7:0]                 rd_data,
  output ld_cfg_pkg::mode_t          mode,
  output logic                       soft_pulse,
  output ld_cfg_pkg::bank_t          bank
);
  import ld_cfg_pkg::*;

  logic [7:0] index_reg;
  logic [7:0] dev_sel;
  logic       data_wr;
  logic       data_rd;
  logic       rst_all;
  logic       rst_nosoft;
  logic       rst_por;
  logic [7:0] wd;

  // data port only counts while configuring
  assign data_wr = host_req.wr && host_req.data_port && (mode == cfg_mode);
  assign data_rd = host_req.rd && host_req.data_port && (mode == cfg_mode);
  assign wd      = host_req.wdata;

  // reset groups; a register loads its default if any member is active
  assign rst_all    = sys_rst | hard_reset | main_por | soft_pulse;
  assign rst_nosoft = sys_rst | hard_reset | main_por;
  assign rst_por    = sys_rst | main_por;

  // device registers only from 0x30 up, in the selected device
  function automatic logic hit(input logic [7:0] ld, input logic [7:0] idx);
    hit = data_wr && (index_reg >= IDX_LD_FIRST) && (dev_sel == ld) &&
          (index_reg == idx);
  endfunction

  // key sequence on the index port
  always_ff @(posedge sys_clk) begin
    if (sys_rst || hard_reset) begin
      mode <= run_mode;
    end else if (host_req.wr && !host_req.data_port) begin
      if (mode == run_mode && wd == KEY_ENTER) begin
        mode <= cfg_mode;
      end else if (mode == cfg_mode && wd == KEY_EXIT) begin
        mode <= run_mode;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || hard_reset) begin
      index_reg <= RST_ZERO;
    end else if (host_req.wr && !host_req.data_port && mode == cfg_mode &&
                 wd != KEY_EXIT) begin
      index_reg <= wd;
    end
  end

  // one-cycle pulse, never held by software
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      soft_pulse <= 1'b0;
    end else begin
      soft_pulse <= data_wr && index_reg == IDX_CFG_CTRL && wd[SOFT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      dev_sel <= RST_ZERO;
    end else if (data_wr && index_reg == IDX_DEV_SELECT) begin
      dev_sel <= wd;
    end
  end

  // reset on all four sources
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      bank.printer_activate      <= RST_ZERO;
      bank.printer_base_address  <= RST_BASE;
      bank.printer_irq_select    <= RST_ZERO;
      bank.printer_dma_select    <= RST_PRINTER_DMA;
      bank.serial_a_activate     <= RST_ZERO;
      bank.serial_a_base_address <= RST_BASE;
      bank.serial_a_irq_select   <= RST_ZERO;
      bank.serial_b_activate     <= RST_ZERO;
      bank.serial_b_base_address <= RST_BASE;
      bank.serial_b_spare_pair   <= RST_BASE;
      bank.serial_b_irq_select   <= RST_ZERO;
      bank.keyboard_activate     <= RST_ZERO;
      bank.keyboard_irq_select   <= RST_ZERO;
      bank.mouse_irq_select      <= RST_ZERO;
      bank.aux_activate          <= RST_ZERO;
    end else begin
      if (hit(LD_PRINTER, IDX_ACTIVATE)) bank.printer_activate <= wd;
      if (hit(LD_PRINTER, IDX_BASE_HI)) bank.printer_base_address[15:8] <= wd;
      if (hit(LD_PRINTER, IDX_BASE_LO)) bank.printer_base_address[7:0] <= wd;
      if (hit(LD_PRINTER, IDX_IRQ)) bank.printer_irq_select <= wd;
      if (hit(LD_PRINTER, IDX_DMA)) bank.printer_dma_select <= wd;
      if (hit(LD_SERIAL_A, IDX_ACTIVATE)) bank.serial_a_activate <= wd;
      if (hit(LD_SERIAL_A, IDX_BASE_HI))
        bank.serial_a_base_address[15:8] <= wd;
      if (hit(LD_SERIAL_A, IDX_BASE_LO))
        bank.serial_a_base_address[7:0] <= wd;
      if (hit(LD_SERIAL_A, IDX_IRQ)) bank.serial_a_irq_select <= wd;
      if (hit(LD_SERIAL_B, IDX_ACTIVATE)) bank.serial_b_activate <= wd;
      if (hit(LD_SERIAL_B, IDX_BASE_HI))
        bank.serial_b_base_address[15:8] <= wd;
      if (hit(LD_SERIAL_B, IDX_BASE_LO))
        bank.serial_b_base_address[7:0] <= wd;
      if (hit(LD_SERIAL_B, IDX_SPARE_HI)) bank.serial_b_spare_pair[15:8] <= wd;
      if (hit(LD_SERIAL_B, IDX_SPARE_LO)) bank.serial_b_spare_pair[7:0] <= wd;
      if (hit(LD_SERIAL_B, IDX_IRQ)) bank.serial_b_irq_select <= wd;
      if (hit(LD_KEYBOARD, IDX_ACTIVATE)) bank.keyboard_activate <= wd;
      if (hit(LD_KEYBOARD, IDX_IRQ)) bank.keyboard_irq_select <= wd;
      if (hit(LD_KEYBOARD, IDX_IRQ_2ND)) bank.mouse_irq_select <= wd;
      if (hit(LD_AUX, IDX_ACTIVATE)) bank.aux_activate <= wd;
    end
  end

  // soft reset leaves these alone
  always_ff @(posedge sys_clk) begin
    if (rst_nosoft) begin
      bank.floppy_mode_cfg             <= RST_FLOPPY_MODE;
      bank.floppy_option_cfg           <= RST_ZERO;
      bank.floppy_type_cfg             <= RST_FLOPPY_TYPE;
      bank.floppy_drive_a_cfg          <= RST_ZERO;
      bank.floppy_drive_b_cfg          <= RST_ZERO;
      bank.printer_mode_cfg            <= RST_PRINTER_MODE;
      bank.printer_mode_cfg_second     <= RST_ZERO;
      bank.serial_a_mode_cfg           <= RST_ZERO;
      bank.serial_b_mode_cfg           <= RST_ZERO;
      bank.infrared_options            <= RST_IR_OPTIONS;
      bank.infrared_turnaround_timeout <= RST_IR_TIMEOUT;
      bank.keyboard_reset_gate_select  <= RST_ZERO;
      bank.pin_sharing_controls        <= RST_PIN_MUX;
      bank.media_change_force          <= RST_MEDIA;
      bank.watchdog_timeout_cfg        <= RST_ZERO;
      bank.watchdog_count              <= RST_ZERO;
      bank.watchdog_setup              <= RST_ZERO;
    end else begin
      if (hit(LD_FLOPPY, IDX_F0)) bank.floppy_mode_cfg <= wd;
      if (hit(LD_FLOPPY, IDX_F1)) bank.floppy_option_cfg <= wd;
      if (hit(LD_FLOPPY, IDX_F2)) bank.floppy_type_cfg <= wd;
      if (hit(LD_FLOPPY, IDX_F4)) bank.floppy_drive_a_cfg <= wd;
      if (hit(LD_FLOPPY, IDX_F5)) bank.floppy_drive_b_cfg <= wd;
      if (hit(LD_PRINTER, IDX_F0)) bank.printer_mode_cfg <= wd;
      if (hit(LD_PRINTER, IDX_F1)) bank.printer_mode_cfg_second <= wd;
      if (hit(LD_SERIAL_A, IDX_F0)) bank.serial_a_mode_cfg <= wd;
      if (hit(LD_SERIAL_B, IDX_F0)) bank.serial_b_mode_cfg <= wd;
      if (hit(LD_SERIAL_B, IDX_F1)) bank.infrared_options <= wd;
      if (hit(LD_SERIAL_B, IDX_F2)) bank.infrared_turnaround_timeout <= wd;
      if (hit(LD_KEYBOARD, IDX_F0)) bank.keyboard_reset_gate_select <= wd;
      if (hit(LD_AUX, IDX_PIN_MUX)) bank.pin_sharing_controls <= wd;
      if (hit(LD_AUX, IDX_MEDIA)) bank.media_change_force <= wd;
      if (hit(LD_AUX, IDX_F1)) bank.watchdog_timeout_cfg <= wd;
      if (hit(LD_AUX, IDX_F2)) bank.watchdog_count <= wd;
      if (hit(LD_AUX, IDX_F3)) bank.watchdog_setup <= wd;
    end
  end

  // power-on only; hard and soft reset keep them
  always_ff @(posedge sys_clk) begin
    if (rst_por) begin
      bank.mgmt_event_enable_a <= RST_ZERO;
      bank.mgmt_event_enable_b <= RST_ZERO;
      bank.mgmt_event_status_a <= RST_ZERO;
      bank.mgmt_event_status_b <= RST_ZERO;
    end else begin
      if (hit(LD_AUX, IDX_EVT_EN_A)) bank.mgmt_event_enable_a <= wd;
      if (hit(LD_AUX, IDX_EVT_EN_B)) bank.mgmt_event_enable_b <= wd;
      if (hit(LD_AUX, IDX_EVT_ST_A)) bank.mgmt_event_status_a <= wd;
      if (hit(LD_AUX, IDX_EVT_ST_B)) bank.mgmt_event_status_b <= wd;
    end
  end

  // standby-supply power-on only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank.power_event_control <= RST_ZERO;
      bank.wake_event_enable   <= RST_ZERO;
      bank.watchdog_command    <= RST_ZERO;
    end else begin
      if (hit(LD_AUX, IDX_PWR_CTL)) bank.power_event_control <= wd;
      if (hit(LD_AUX, IDX_WAKE_EN)) bank.wake_event_enable <= wd;
      // only the write-only bits are stored
      if (hit(LD_AUX, IDX_F4)) bank.watchdog_command <= wd & WDT_WRITE_MASK;
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank.power_event_status <= RST_ZERO;
      bank.wake_event_status  <= RST_ZERO;
    end else begin
      bank.power_event_status <= (bank.power_event_status &
        ~(hit(LD_AUX, IDX_PWR_ST) ? wd : RST_ZERO)) | power_event_set;
      bank.wake_event_status <= (bank.wake_event_status &
        ~(hit(LD_AUX, IDX_WAKE_ST) ? wd : RST_ZERO)) | wake_event_set;
    end
  end

  // read value of the addressed register; zero where nothing lives
  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    logic [7:0] v;
    v = RST_ZERO;
    if (idx == IDX_DEV_SELECT) begin
      v = dev_sel;
    end else if (idx >= IDX_LD_FIRST) begin
      unique case (dev_sel)
        LD_FLOPPY: begin
          if (idx == IDX_F0) v = bank.floppy_mode_cfg;
          if (idx == IDX_F1) v = bank.floppy_option_cfg;
          if (idx == IDX_F2) v = bank.floppy_type_cfg;
          if (idx == IDX_F4) v = bank.floppy_drive_a_cfg;
          if (idx == IDX_F5) v = bank.floppy_drive_b_cfg;
        end
        LD_PRINTER: begin
          if (idx == IDX_ACTIVATE) v = bank.printer_activate;
          if (idx == IDX_BASE_HI) v = bank.printer_base_address[15:8];
          if (idx == IDX_BASE_LO) v = bank.printer_base_address[7:0];
          if (idx == IDX_IRQ) v = bank.printer_irq_select;
          if (idx == IDX_DMA) v = bank.printer_dma_select;
          if (idx == IDX_F0) v = bank.printer_mode_cfg;
          if (idx == IDX_F1) v = bank.printer_mode_cfg_second;
        end
        LD_SERIAL_A: begin
          if (idx == IDX_ACTIVATE) v = bank.serial_a_activate;
          if (idx == IDX_BASE_HI) v = bank.serial_a_base_address[15:8];
          if (idx == IDX_BASE_LO) v = bank.serial_a_base_address[7:0];
          if (idx == IDX_IRQ) v = bank.serial_a_irq_select;
          if (idx == IDX_F0) v = bank.serial_a_mode_cfg;
        end
        LD_SERIAL_B: begin
          if (idx == IDX_ACTIVATE) v = bank.serial_b_activate;
          if (idx == IDX_BASE_HI) v = bank.serial_b_base_address[15:8];
          if (idx == IDX_BASE_LO) v = bank.serial_b_base_address[7:0];
          if (idx == IDX_SPARE_HI) v = bank.serial_b_spare_pair[15:8];
          if (idx == IDX_SPARE_LO) v = bank.serial_b_spare_pair[7:0];
          if (idx == IDX_IRQ) v = bank.serial_b_irq_select;
          if (idx == IDX_F0) v = bank.serial_b_mode_cfg;
          if (idx == IDX_F1) v = bank.infrared_options;
          if (idx == IDX_F2) v = bank.infrared_turnaround_timeout;
        end
        LD_KEYBOARD: begin
          if (idx == IDX_ACTIVATE) v = bank.keyboard_activate;
          if (idx == IDX_IRQ) v = bank.keyboard_irq_select;
          if (idx == IDX_IRQ_2ND) v = bank.mouse_irq_select;
          if (idx == IDX_F0) v = bank.keyboard_reset_gate_select;
        end
        LD_AUX: begin
          if (idx == IDX_ACTIVATE) v = bank.aux_activate;
          if (idx == IDX_EVT_EN_A) v = bank.mgmt_event_enable_a;
          if (idx == IDX_EVT_EN_B) v = bank.mgmt_event_enable_b;
          if (idx == IDX_EVT_ST_A) v = bank.mgmt_event_status_a;
          if (idx == IDX_EVT_ST_B) v = bank.mgmt_event_status_b;
          if (idx == IDX_PIN_MUX) v = bank.pin_sharing_controls;
          if (idx == IDX_MEDIA) v = bank.media_change_force;
          if (idx == IDX_RATE_MIR) v = floppy_rate_src;
          if (idx == IDX_FIFO_A) v = serial_a_fifo_src;
          if (idx == IDX_FIFO_B) v = serial_b_fifo_src;
          if (idx == IDX_PWR_CTL) v = bank.power_event_control;
          if (idx == IDX_PWR_ST) v = bank.power_event_status;
          if (idx == IDX_WAKE_ST) v = bank.wake_event_status;
          if (idx == IDX_WAKE_EN) v = bank.wake_event_enable;
          if (idx == IDX_F1) v = bank.watchdog_timeout_cfg;
          if (idx == IDX_F2) v = bank.watchdog_count;
          if (idx == IDX_F3) v = bank.watchdog_setup;
          // write-only bits hidden, read-only bits from the timer
          if (idx == IDX_F4) v = watchdog_state & WDT_READ_MASK;
        end
        default: v = RST_ZERO;  // reserved devices
      endcase
    end
    read_mux = v;
  endfunction

  // read data holds until the next read; run mode reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= RST_ZERO;
    end else if (host_req.rd) begin
      if (mode != cfg_mode) begin
        rd_data <= RST_ZERO;
      end else if (!host_req.data_port) begin
        rd_data <= index_reg;
      end else begin
        rd_data <= read_mux(index_reg);
      end
    end
  end

  chk_soft_self_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_pulse |=> !soft_pulse) else $error("soft pulse held");
  chk_soft_trigger: assert property (@(posedge sys_clk) disable iff (sys_rst)
    data_wr && index_reg == IDX_CFG_CTRL && wd[SOFT_BIT] |=> soft_pulse)
    else $error("soft reset missed");
  chk_run_read_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    host_req.rd && mode == run_mode |=> rd_data == RST_ZERO)
    else $error("run mode read not zero");
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    data_rd && index_reg >= IDX_LD_FIRST && dev_sel == 8'h01
    |=> rd_data == RST_ZERO) else $error("reserved read not zero");
  chk_base_cleared: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_pulse |=> bank.serial_b_base_address == RST_BASE &&
    bank.printer_base_address == RST_BASE) else $error("base kept");
  chk_modes_keep_soft: assert property (@(posedge sys_clk)
    disable iff (sys_rst) soft_pulse && !hard_reset && !main_por && !data_wr
    |=> $stable(bank.printer_mode_cfg) && $stable(bank.serial_a_mode_cfg) &&
    $stable(bank.serial_b_mode_cfg)) else $error("mode lost");
  chk_ir_defaults: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hard_reset |=> bank.infrared_options == RST_IR_OPTIONS &&
    bank.infrared_turnaround_timeout == RST_IR_TIMEOUT &&
    bank.floppy_type_cfg == RST_FLOPPY_TYPE)
    else $error("ir default wrong");
  chk_keyboard_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    main_por |=> bank.keyboard_activate == RST_ZERO &&
    bank.mouse_irq_select == RST_ZERO && bank.keyboard_reset_gate_select ==
    RST_ZERO) else $error("keyboard not cleared");
  chk_enable_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hard_reset || soft_pulse) && !main_por && !data_wr
    |=> $stable(bank.mgmt_event_enable_a) &&
    $stable(bank.mgmt_event_status_b)) else $error("event reg lost");
  chk_status_set_wins: assert property (@(posedge sys_clk)
    disable iff (sys_rst) |power_event_set |=> (bank.power_event_status &
    $past(power_event_set)) == $past(power_event_set))
    else $error("event lost");
  chk_standby_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hard_reset || main_por) && !data_wr |=> $stable(bank.power_event_control)
    && $stable(bank.wake_event_enable)) else $error("standby reg lost");
endmodule

// [verification/host_port_model.sv]
// host side of the index and data ports, one byte cycle per call
// assumes the bank samples strobes on the rising edge of sys_clk
`timescale 1ns/10ps
module host_port_model
  import ld_cfg_pkg::*;
(
  input  wire logic             sys_clk,
  output ld_cfg_pkg::host_req_t req,
  input  wire logic [7:0]       rd_data
);
  initial req = '0;
  // strobe held one edge, then dropped: the bank wants pulses
  task automatic put(input logic p, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, p, d};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic get(output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, 1'b1, 8'h00};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
    #1 d = rd_data;
  endtask
endmodule

// [verification/test_logical_device_config_bank.sv]
// self-checking bench of the bank through its host model
// assumes a 40 MHz clock and one-cycle reset source pulses
`timescale 1ns/10ps
module test_logical_device_config_bank;
  import ld_cfg_pkg::*;
  logic       sys_clk = 0, sys_rst = 1, hard_reset = 0, main_por = 0;
  logic [7:0] rate = 8'h00, pset = 8'h00, wst = 8'ha5, rd_data, got;
  logic [7:0] val [16];
  mode_t      mode;
  logic       soft_pulse;
  bank_t      bank;
  host_req_t  req;
  integer     seed = 32'h2f4f;
  int         err_total = 0, tests_run = 0;
  // dev, index, default, mask of sources (stby, soft, main, hard)
  localparam logic [27:0] TAB [16] = '{
    {8'h03,8'h30,8'h00,4'hf}, {8'h03,8'h60,8'h00,4'hf},
    {8'h04,8'h61,8'h00,4'hf}, {8'h05,8'h60,8'h00,4'hf},
    {8'h03,8'hf0,8'h3c,4'hb}, {8'h03,8'hf1,8'h00,4'hb},
    {8'h04,8'hf0,8'h00,4'hb}, {8'h05,8'hf0,8'h00,4'hb},
    {8'h05,8'hf1,8'h02,4'hb}, {8'h05,8'hf2,8'h03,4'hb},
    {8'h07,8'h72,8'h00,4'hf}, {8'h07,8'hf0,8'h00,4'hb},
    {8'h08,8'hb5,8'h00,4'ha}, {8'h08,8'hb7,8'h00,4'ha},
    {8'h08,8'hc8,8'h00,4'h8}, {8'h00,8'hf2,8'hff,4'hb}};
  always #12.5 sys_clk = ~sys_clk;
  logical_device_config_bank i_logical_device_config_bank (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hard_reset(hard_reset),
    .main_por(main_por), .host_req(req), .floppy_rate_src(rate),
    .serial_a_fifo_src(8'h00), .serial_b_fifo_src(8'h00),
    .power_event_set(pset), .wake_event_set(8'h00),
    .watchdog_state(wst), .rd_data(rd_data), .mode(mode),
    .soft_pulse(soft_pulse), .bank(bank));
  host_port_model i_host_port_model (
    .sys_clk(sys_clk), .req(req), .rd_data(rd_data));
  function automatic logic [7:0] expect_val(input logic [27:0] t,
                                            input int s, input logic [7:0] v);
    return t[s] ? t[11:4] : v;
  endfunction
  task automatic check(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] i, d);
    i_host_port_model.put(1'b0, i);
    i_host_port_model.put(1'b1, d);
  endtask
  task automatic rreg(input logic [7:0] i, output logic [7:0] d);
    i_host_port_model.put(1'b0, i);
    i_host_port_model.get(d);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic pulse(input int s);
    @(posedge sys_clk);
    hard_reset <= (s == 0);
    main_por <= (s == 1);
    sys_rst <= (s == 3);
    if (s == 2) wreg(IDX_CFG_CTRL, 8'h01);
    @(posedge sys_clk);
    {hard_reset, main_por, sys_rst} <= 3'b000;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rate <= $random(seed);
    i_host_port_model.get(got);
    check("run read", got, 8'h00);
    i_host_port_model.put(1'b0, KEY_ENTER);
    // each source in turn; written values must survive unmarked ones
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 16; k++) begin
        val[k] = $random(seed);
        wreg(IDX_DEV_SELECT, TAB[k][27:20]);
        wreg(TAB[k][19:12], val[k]);
      end
      pulse(s);
      i_host_port_model.put(1'b0, KEY_ENTER);
      for (int k = 0; k < 16; k++) begin
        wreg(IDX_DEV_SELECT, TAB[k][27:20]);
        rreg(TAB[k][19:12], got);
        check("reg", got, expect_val(TAB[k], s, val[k]));
      end
    end
    rreg(IDX_CFG_CTRL, got);
    check("soft bit", got, 8'h00);
    wreg(IDX_DEV_SELECT, 8'h01);
    wreg(IDX_ACTIVATE, 8'hff);
    rreg(IDX_ACTIVATE, got);
    check("reserved dev", got, 8'h00);
    wreg(IDX_DEV_SELECT, LD_AUX);
    rreg(IDX_RATE_MIR, got);
    check("rate mirror", got, rate);
    rreg(IDX_F4, got);
    check("watchdog", got, wst & WDT_READ_MASK);
    @(posedge sys_clk);
    pset <= 8'h81;
    @(posedge sys_clk);
    pset <= 8'h00;
    wreg(IDX_PWR_ST, 8'h01);
    rreg(IDX_PWR_ST, got);
    check("event clear", got, 8'h80);
    i_host_port_model.put(1'b0, KEY_EXIT);
    i_host_port_model.put(1'b1, 8'h11);
    i_host_port_model.put(1'b0, KEY_ENTER);
    rreg(IDX_PWR_ST, got);
    check("run write", got, 8'h80);
    end_sim();
  end
  // about 1200 cycles expected; 5000 allowed
  initial begin
    #125000;
    err_total++;
    end_sim();
  end
endmodule
